/* File: src/atp_pkg.sv */
// constants, field layout and mode types for the 8-bit timer with prescaler
// What this block does
// - timer source is the bus clock, or oscillator pin edges when async select set.
// - async select detaches both oscillator pins from their port function.
// - clock select: stop, /1, /8, /32, /64, /128, /256, /1024.
// - prescaler reset bit clears the prescaler divider for a predictable tick.
// - force strobe in non-PWM mode applies the compare action at once.
// - forced compare sets no flag and never clears the counter.
// - force strobe is write only and reads back zero.
// - mode field, high bit 3, low bit 6: normal, phase PWM, CLEAR_ON_MATCH_MODE, fast PWM.
// - TOP, compare buffer update point and overflow point depend on mode.
// - nonzero output mode overrides port; driver enabled only with direction bit.
// - non-PWM output modes: off, toggle, clear, set on match.
// - fast PWM: 10 clear on match set at bottom, 11 inverted.
// - phase PWM: 10 clear on up match set on down match, 11 inverted.
// - compare equal TOP in PWM with high output mode bit: match ignored, action at bottom/top.
// - counter register gives direct read and write access to the count.
// - counter write blocks the compare match on the next timer tick.
// - compare register compared always; match sets flag and drives output.
// - async writes go to holding registers, moved after two oscillator edges.
// - async reads of compare and control return holding registers.
// - prescaler reset bit self clears; in async mode stays set until done.
package atp_pkg;
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] ADDR_CTL = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_CNT = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_OCR = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_ASYNC = 5'h0C;
  localparam logic [ADDR_W-1:0] ADDR_SFR = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_FLAG = 5'h14;
  localparam logic [ADDR_W-1:0] ADDR_PIN = 5'h18;
  localparam int ASYNC_SEL_BIT = 3;
  localparam int PSR_BIT = 1;
  localparam int FLAG_CMP_BIT = 7;
  localparam int FLAG_OVF_BIT = 6;
  localparam int PIN_DIR_BIT = 0;
  // slot index equals the busy bit position in the async status register
  localparam int SLOT_CTL = 0;
  localparam int SLOT_OCR = 1;
  localparam int SLOT_CNT = 2;
  localparam int SLOTS = 3;
  localparam logic [1:0] XFER_EDGES = 2'h2;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] OUT_OFF = 2'h0;
  localparam logic [1:0] OUT_TOGGLE = 2'h1;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [3:0] SHIFT_DIV8 = 4'h3;
  localparam logic [3:0] SHIFT_DIV32 = 4'h5;
  localparam logic [3:0] SHIFT_DIV64 = 4'h6;
  localparam logic [3:0] SHIFT_DIV128 = 4'h7;
  localparam logic [3:0] SHIFT_DIV256 = 4'h8;
  localparam logic [3:0] SHIFT_DIV1024 = 4'hA;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic force_compare_strobe;
    logic wave_mode_low;
    logic [1:0] out_mode;
    logic wave_mode_high;
    logic [2:0] clock_sel;
  } atp_ctl_s;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_PHASE_PWM,
    MODE_CLEAR_ON_MATCH,
    MODE_FAST_PWM
  } atp_mode_e;
endpackage

/* File: src/atp_sync_rise.sv */
// two-flop synchroniser with rising edge pulse
`timescale 1ns/10ps
module atp_sync_rise (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic async_in,
  output logic rise
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign rise = sync_ff & ~last_ff;
endmodule

/* File: src/atp_prescaler.sv */
// free-running prescaler with tap select
`timescale 1ns/10ps
module atp_prescaler
  import atp_pkg::*;
#(
  parameter int DIV_W = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic src_tick,
  input wire logic psr_clear,
  input wire logic [2:0] clock_sel,
  output logic tick
);
  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] tap_mask;
  logic [3:0] tap_w;

  function automatic logic [3:0] tap_width(input logic [2:0] sel);
    case (sel)
      3'h2: tap_width = SHIFT_DIV8;
      3'h3: tap_width = SHIFT_DIV32;
      3'h4: tap_width = SHIFT_DIV64;
      3'h5: tap_width = SHIFT_DIV128;
      3'h6: tap_width = SHIFT_DIV256;
      3'h7: tap_width = SHIFT_DIV1024;
      default: tap_width = 4'h0;
    endcase
  endfunction

  assign tap_w = tap_width(clock_sel);

  genvar i;
  generate
    for (i = 0; i < DIV_W; i++) begin : g_mask
      assign tap_mask[i] = (i < int'(tap_w));
    end
  endgenerate

  // tick when every tapped low bit is one: one enable per division period
  assign tick = (clock_sel != CS_STOP) & src_tick & (&(div_ff | ~tap_mask));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= '0;
    end else if (psr_clear) begin
      div_ff <= '0;
    end else if (src_tick) begin
      div_ff <= div_ff + 1'b1;
    end
  end
endmodule

/* File: src/atp_timer.sv */
// 8-bit timer with prescaler, async holding registers and AXI4-Lite slave
`timescale 1ns/10ps
module atp_timer
  import atp_pkg::*;
#(
  parameter int DIV_W = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic osc_in_pin,
  output logic osc_pins_detached,
  output logic compare_output_pin,
  output logic compare_pin_oe,
  output logic compare_override
);
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_have_ff, w_have_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [7:0] wbyte_ff;
  logic wlane_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  atp_ctl_s ctl_ff;
  logic [7:0] hold_ff [SLOTS];
  logic [SLOTS-1:0] busy_ff;
  logic [1:0] ecnt_ff [SLOTS];
  logic [7:0] cnt_ff, ocr_buf_ff, ocr_ff;
  logic dir_down_ff, oc_ff, block_ff, async_ff, psr_ff, pin_dir_ff;
  logic cmp_flag_ff, ovf_flag_ff, pin_oe_ff, override_ff, detached_ff;

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = (a == ADDR_CTL) | (a == ADDR_CNT) | (a == ADDR_OCR) |
                  (a == ADDR_ASYNC) | (a == ADDR_SFR) | (a == ADDR_FLAG) |
                  (a == ADDR_PIN);
  endfunction

  // bus write decode
  logic wr_do, wr_ok, osc_rise, src_tick, psr_clear, tick;
  logic [SLOTS-1:0] wr_slot, xfer;
  logic [7:0] slot_val [SLOTS];
  logic wr_async, wr_sfr, wr_flag, wr_pin;
  assign wr_do = aw_have_ff & w_have_ff & ~bvalid_ff;
  assign wr_ok = wr_do & wlane_ff;
  assign wr_slot[SLOT_CTL] = wr_ok & (awaddr_ff == ADDR_CTL);
  assign wr_slot[SLOT_OCR] = wr_ok & (awaddr_ff == ADDR_OCR);
  assign wr_slot[SLOT_CNT] = wr_ok & (awaddr_ff == ADDR_CNT);
  assign wr_async = wr_ok & (awaddr_ff == ADDR_ASYNC);
  assign wr_sfr = wr_ok & (awaddr_ff == ADDR_SFR);
  assign wr_flag = wr_ok & (awaddr_ff == ADDR_FLAG);
  assign wr_pin = wr_ok & (awaddr_ff == ADDR_PIN);

  atp_sync_rise u_osc_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(osc_in_pin),
    .rise(osc_rise)
  );

  // oscillator edges must be well below aclk/4 to be seen as separate ticks
  assign src_tick = async_ff ? osc_rise : 1'b1;
  assign psr_clear = psr_ff & src_tick;

  atp_prescaler #(.DIV_W(DIV_W)) u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .src_tick(src_tick),
    .psr_clear(psr_clear),
    .clock_sel(ctl_ff.clock_sel),
    .tick(tick)
  );

  // holding registers: sync mode transfers at once, async after two edges
  genvar s;
  generate
    for (s = 0; s < SLOTS; s++) begin : g_slot
      assign xfer[s] = async_ff ?
        (busy_ff[s] & osc_rise & (ecnt_ff[s] == XFER_EDGES - 2'h1)) :
        wr_slot[s];
      assign slot_val[s] = async_ff ? hold_ff[s] : wbyte_ff;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          hold_ff[s] <= BYTE_ZERO;
          busy_ff[s] <= 1'b0;
          ecnt_ff[s] <= 2'h0;
        end else if (wr_slot[s]) begin
          hold_ff[s] <= wbyte_ff;
          busy_ff[s] <= async_ff;
          ecnt_ff[s] <= 2'h0;
        end else if (busy_ff[s] & osc_rise) begin
          busy_ff[s] <= ~xfer[s];
          ecnt_ff[s] <= ecnt_ff[s] + 2'h1;
        end
      end
    end
  endgenerate

  // counting and waveform decode
  atp_ctl_s new_ctl;
  atp_mode_e mode, new_mode;
  logic is_pwm, phase, fast, clear_on_match_mode, at_top, match, top_ignore, force_evt;
  logic turn_top, turn_bot, wrap_evt, ovf_evt, ocr_load, nxt_dir, nxt_oc;
  logic np_act, fp_act, pp_act;
  logic [1:0] act_com;
  logic [7:0] top, cnt_up, cnt_dn, nxt_cnt;
  assign new_ctl = atp_ctl_s'(slot_val[SLOT_CTL]);
  assign mode = atp_mode_e'({ctl_ff.wave_mode_high, ctl_ff.wave_mode_low});
  assign new_mode = atp_mode_e'({new_ctl.wave_mode_high, new_ctl.wave_mode_low});
  assign phase = (mode == MODE_PHASE_PWM);
  assign fast = (mode == MODE_FAST_PWM);
  assign clear_on_match_mode = (mode == MODE_CLEAR_ON_MATCH);
  assign is_pwm = phase | fast;
  assign top = clear_on_match_mode ? ocr_ff : COUNT_MAX;
  assign at_top = (cnt_ff == top);
  assign cnt_up = cnt_ff + 8'h01;
  assign cnt_dn = cnt_ff - 8'h01;
  assign turn_top = phase & ~dir_down_ff & (cnt_ff == COUNT_MAX);
  assign turn_bot = phase & dir_down_ff & (cnt_ff == COUNT_BOTTOM);
  assign nxt_dir = turn_top ? 1'b1 : (turn_bot ? 1'b0 : dir_down_ff);
  assign nxt_cnt = phase ? (nxt_dir ? cnt_dn : cnt_up) :
                   (at_top ? COUNT_BOTTOM : cnt_up);
  assign match = tick & (cnt_ff == ocr_ff) & ~block_ff;
  assign wrap_evt = tick & fast & (cnt_ff == COUNT_MAX);
  assign ovf_evt = tick & ~xfer[SLOT_CNT] &
                   (phase ? turn_bot : (cnt_ff == COUNT_MAX));
  assign ocr_load = ~is_pwm |
                    (tick & (fast ? (cnt_ff == COUNT_MAX) : turn_top));
  assign top_ignore = is_pwm & ctl_ff.out_mode[1] & (ocr_ff == COUNT_MAX);
  // the forced action follows the output mode written with the strobe
  assign force_evt = xfer[SLOT_CTL] & new_ctl.force_compare_strobe &
                     (new_mode != MODE_PHASE_PWM) &
                     (new_mode != MODE_FAST_PWM);
  assign act_com = force_evt ? new_ctl.out_mode : ctl_ff.out_mode;
  assign np_act = (force_evt | (match & ~is_pwm)) & (act_com != OUT_OFF);
  assign fp_act = fast & ctl_ff.out_mode[1];
  assign pp_act = phase & ctl_ff.out_mode[1];
  assign nxt_oc =
    np_act ? ((act_com == OUT_TOGGLE) ? ~oc_ff : act_com[0]) :
    (fp_act & wrap_evt) ? ~ctl_ff.out_mode[0] :
    (fp_act & match & ~top_ignore) ? ctl_ff.out_mode[0] :
    (pp_act & match & ~top_ignore) ?
      (dir_down_ff ^ ctl_ff.out_mode[0]) :
    (pp_act & top_ignore & tick & turn_top) ? ctl_ff.out_mode[0] :
    oc_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_ff <= atp_ctl_s'(BYTE_ZERO);
      cnt_ff <= COUNT_BOTTOM;
      dir_down_ff <= 1'b0;
      block_ff <= 1'b0;
      oc_ff <= 1'b0;
    end else begin
      if (xfer[SLOT_CTL]) begin
        ctl_ff <= new_ctl;
        ctl_ff.force_compare_strobe <= 1'b0;
      end
      if (xfer[SLOT_CNT]) begin
        cnt_ff <= slot_val[SLOT_CNT];
        block_ff <= 1'b1;
      end else if (tick) begin
        cnt_ff <= nxt_cnt; // forced strobes never reach this
        dir_down_ff <= nxt_dir;
        block_ff <= 1'b0;
      end
      oc_ff <= nxt_oc;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ocr_buf_ff <= BYTE_ZERO;
      ocr_ff <= BYTE_ZERO;
    end else begin
      if (xfer[SLOT_OCR]) begin
        ocr_buf_ff <= slot_val[SLOT_OCR];
      end
      if (ocr_load) begin
        ocr_ff <= ocr_buf_ff;
      end
    end
  end

  // flags: hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_flag_ff <= 1'b0;
      ovf_flag_ff <= 1'b0;
      async_ff <= 1'b0;
      psr_ff <= 1'b0;
      pin_dir_ff <= 1'b0;
    end else begin
      cmp_flag_ff <= match | (cmp_flag_ff &
                     ~(wr_flag & wbyte_ff[FLAG_CMP_BIT]));
      ovf_flag_ff <= ovf_evt | (ovf_flag_ff &
                     ~(wr_flag & wbyte_ff[FLAG_OVF_BIT]));
      if (wr_async) begin
        async_ff <= wbyte_ff[ASYNC_SEL_BIT];
      end
      if (wr_sfr & wbyte_ff[PSR_BIT]) begin
        psr_ff <= 1'b1;
      end else if (psr_clear) begin
        psr_ff <= 1'b0;
      end
      if (wr_pin) begin
        pin_dir_ff <= wbyte_ff[PIN_DIR_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_oe_ff <= 1'b0;
      override_ff <= 1'b0;
      detached_ff <= 1'b0;
    end else begin
      override_ff <= (ctl_ff.out_mode != OUT_OFF);
      pin_oe_ff <= (ctl_ff.out_mode != OUT_OFF) & pin_dir_ff;
      detached_ff <= async_ff;
    end
  end

  // bus read mux
  logic [7:0] rd_byte;
  logic [7:0] ctl_rd;
  assign ctl_rd = {1'b0, hold_ff[SLOT_CTL][6:0]};
  assign rd_byte =
    (s_axi_araddr == ADDR_CTL) ? ctl_rd :
    (s_axi_araddr == ADDR_CNT) ? cnt_ff :
    (s_axi_araddr == ADDR_OCR) ? hold_ff[SLOT_OCR] :
    (s_axi_araddr == ADDR_ASYNC) ? {4'h0, async_ff, busy_ff} :
    (s_axi_araddr == ADDR_SFR) ? {6'h00, psr_ff & async_ff, 1'b0} :
    (s_axi_araddr == ADDR_FLAG) ? {cmp_flag_ff, ovf_flag_ff, 6'h00} :
    (s_axi_araddr == ADDR_PIN) ? {7'h00, pin_dir_ff} : BYTE_ZERO;

  // AXI4-Lite slave: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awaddr_ff <= '0;
      wbyte_ff <= BYTE_ZERO;
      wlane_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid & awready_ff) begin
        awready_ff <= 1'b0;
        aw_have_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (~aw_have_ff & ~bvalid_ff) begin
        awready_ff <= 1'b1;
      end
      if (s_axi_wvalid & wready_ff) begin
        wready_ff <= 1'b0;
        w_have_ff <= 1'b1;
        wbyte_ff <= s_axi_wdata[7:0];
        wlane_ff <= s_axi_wstrb[0];
      end else if (~w_have_ff & ~bvalid_ff) begin
        wready_ff <= 1'b1;
      end
      if (wr_do) begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= addr_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff & s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  logic rd_ctl_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
      rd_ctl_ff <= 1'b0;
    end else if (s_axi_arvalid & arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h000000, rd_byte};
      rresp_ff <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rd_ctl_ff <= (s_axi_araddr == ADDR_CTL);
    end else if (rvalid_ff & s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end else if (~rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign compare_output_pin = oc_ff;
  assign compare_pin_oe = pin_oe_ff;
  assign compare_override = override_ff;
  assign osc_pins_detached = detached_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_force_reads_zero: assert property (
    rvalid_ff & rd_ctl_ff |-> ~rdata_ff[7])
    else $error("force strobe read back as one");
  a_stop_holds: assert property (
    (ctl_ff.clock_sel == CS_STOP) & ~xfer[SLOT_CNT] |=> $stable(cnt_ff))
    else $error("stopped timer counted");
  a_sync_not_busy: assert property (
    ~async_ff & ~$past(async_ff) |-> busy_ff == '0)
    else $error("busy flag in sync mode");
  a_force_no_flag: assert property (
    force_evt & ~match & ~cmp_flag_ff |=> ~cmp_flag_ff)
    else $error("forced compare set the flag");
  a_ctc_wraps: assert property (
    tick & clear_on_match_mode & (cnt_ff == ocr_ff) & ~xfer[SLOT_CNT] |=> cnt_ff == COUNT_BOTTOM)
    else $error("clear-on-match did not wrap");
  a_ovf_at_max: assert property (
    tick & ~phase & (cnt_ff == COUNT_MAX) & ~xfer[SLOT_CNT] |=> ovf_flag_ff)
    else $error("overflow flag missed at max");
  a_write_blocks: assert property (
    xfer[SLOT_CNT] |=> ~match)
    else $error("match right after counter write");
  a_fast_bottom: assert property (
    wrap_evt & ~np_act & (ctl_ff.out_mode == 2'h2) |=> oc_ff)
    else $error("fast pwm not set at bottom");
  a_pin_enable: assert property (
    ~pin_dir_ff & ~$past(pin_dir_ff) |-> ~pin_oe_ff)
    else $error("pin driven without direction bit");
  a_psr_sync_clear: assert property (
    psr_ff & ~async_ff |=> ~psr_ff)
    else $error("prescaler reset bit stuck in sync mode");
  a_async_xfer: assert property (
    $rose(busy_ff[SLOT_OCR]) |-> ~xfer[SLOT_OCR] [*2])
    else $error("async transfer too early");

  c_ctc_wrap: cover property (tick & clear_on_match_mode & at_top);
  c_fast_wrap: cover property (wrap_evt & fp_act);
  c_async_done: cover property ($fell(busy_ff[SLOT_CNT]));
  c_force: cover property (force_evt);
endmodule

/* File: sim/atp_osc_model.sv */
// watch crystal model on the oscillator pin
`timescale 1ns/10ps
module atp_osc_model #(
  parameter real HALF = 500.0
) (
  input wire logic en,
  output logic osc
);
  // crystal only swings once the pins are detached from the port
  // so the pin sits still in sync mode
  initial begin
    osc = 1'b0;
    forever begin
      #HALF;
      osc = en ? ~osc : 1'b0;
    end
  end
endmodule

/* File: sim/atp_timer_tb.sv */
// self-checking bench for the 8-bit timer with prescaler
`timescale 1ns/10ps
module atp_timer_tb;
  import atp_pkg::*;
  logic aclk, aresetn, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
  logic osc, det, pin, oe, ovr;
  logic [ADDR_W-1:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0] ws;
  logic [1:0] bresp, rresp;
  logic [7:0] d;
  int n_mismatch, cmp_count, hi;
  logic [31:0] rq_d[$];
  logic [1:0] rq_r[$];
  logic [1:0] bq[$];
  int rq_t[$];
  string rq_n[$];
  logic [7:0] fb[4] = '{8'hB0, 8'hA0, 8'h90, 8'h90};
  logic fe[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  int sh[6] = '{3, 5, 6, 7, 8, 10};
  // fast, inverted fast, phase, clear-on-match toggle, fast with compare at top
  logic [7:0] pc[5] = '{8'h69, 8'h79, 8'h61, 8'h19, 8'h69};
  int pw[5] = '{512, 512, 510, 258, 512};
  int ph[5] = '{258, 254, 256, 129, 512};

  atp_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .osc_in_pin(osc), .osc_pins_detached(det),
    .compare_output_pin(pin), .compare_pin_oe(oe),
    .compare_override(ovr));
  atp_osc_model xtal (.en(det), .osc(osc));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic fail(input string nm, input logic [31:0] e, logic [31:0] s);
    n_mismatch++;
    $display("[FAIL] %s expected %h seen %h", nm, e, s);
  endtask

  task automatic cmp_bit(input string nm, input logic e, input logic s);
    cmp_count++;
    if (s !== e) fail(nm, {31'h0, e}, {31'h0, s});
  endtask

  task automatic cmp_num(input string nm, input int e, s, t);
    cmp_count++;
    if (s > e + t || s < e - t) fail(nm, e, s);
  endtask

  task automatic chk_rd(input string nm, logic [31:0] e, logic [1:0] r, int t);
    logic bad;
    cmp_count++;
    if (t == 0) bad = rdat !== e;
    else bad = ^rdat === 1'bx || rdat > e + t || rdat + t < e;
    if (bad || rresp !== r) fail(nm, e, rdat);
  endtask

  task automatic chk_b(input logic [1:0] r);
    cmp_count++;
    if (bresp !== r) fail("bresp", {30'h0, r}, {30'h0, bresp});
  endtask

  // scoreboard: oldest note against each response handshake
  always @(posedge aclk) begin
    if (rv === 1'b1 && rr === 1'b1)
      chk_rd(rq_n.pop_front(), rq_d.pop_front(), rq_r.pop_front(),
        rq_t.pop_front());
    if (bv === 1'b1 && br === 1'b1) chk_b(bq.pop_front());
  end

  task automatic wr(input logic [ADDR_W-1:0] a, logic [7:0] v, logic [1:0] r);
    int n;
    bq.push_back(r);
    awa <= a;
    wd <= {24'h0, v};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awr === 1'b1) awv <= 1'b0;
      if (wr_ === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 60);
    br <= 1'b0;
    if (bv !== 1'b1) begin
      n_mismatch++;
      final_report;
    end
    // idle edge keeps the next request one cycle after the handshake
    @(posedge aclk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, logic [31:0] e,
    logic [1:0] r, int t, string nm);
    int n;
    rq_d.push_back(e);
    rq_r.push_back(r);
    rq_t.push_back(t);
    rq_n.push_back(nm);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 60);
    rr <= 1'b0;
    if (rv !== 1'b1) begin
      n_mismatch++;
      final_report;
    end
    @(posedge aclk);
  endtask

  initial begin
    aresetn = 1'b0;
    {awv, wv, br, arv, rr} = 5'h00;
    awa = '0;
    ara = '0;
    wd = '0;
    ws = 4'h1;
    n_mismatch = 0;
    cmp_count = 0;
    d = 8'($urandom(32'hf0211e32));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cmp_bit("override", 1'b0, ovr);
    cmp_bit("pin_oe", 1'b0, oe);
    rd(ADDR_CTL, 32'h00, RESP_OKAY, 0, "ctl_reset");
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      wr(ADDR_CNT, d, RESP_OKAY);
      rd(ADDR_CNT, {24'h0, d}, RESP_OKAY, 0, "count");
      d = 8'($urandom);
      wr(ADDR_OCR, d, RESP_OKAY);
      rd(ADDR_OCR, {24'h0, d}, RESP_OKAY, 0, "compare");
    end
    wr(5'h1C, 8'h00, RESP_SLVERR);
    rd(5'h1C, 32'h00, RESP_SLVERR, 0, "unmapped");
    // a write without the low byte lane must leave the register alone
    ws <= 4'h0;
    wr(ADDR_OCR, ~d, RESP_OKAY);
    ws <= 4'h1;
    rd(ADDR_OCR, {24'h0, d}, RESP_OKAY, 0, "no_lane");
    wr(ADDR_OCR, 8'h00, RESP_OKAY);
    wr(ADDR_PIN, 8'h01, RESP_OKAY);
    // set, clear, toggle twice: toggle alone shows the previous level
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTL, fb[i], RESP_OKAY);
      repeat (3) @(posedge aclk);
      cmp_bit("forced_pin", fe[i], pin);
    end
    cmp_bit("pin_oe", 1'b1, oe);
    cmp_bit("override", 1'b1, ovr);
    rd(ADDR_CTL, 32'h10, RESP_OKAY, 0, "ctl_strobe");
    wr(ADDR_CNT, 8'h33, RESP_OKAY);
    wr(ADDR_FLAG, 8'hC0, RESP_OKAY);
    wr(ADDR_CTL, 8'hB8, RESP_OKAY);
    rd(ADDR_CNT, 32'h33, RESP_OKAY, 0, "ctc_force_count");
    rd(ADDR_FLAG, 32'h00, RESP_OKAY, 0, "force_flags");
    // divider phase is unknown across writes, so one count of slack
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_SFR, 8'h02, RESP_OKAY);
      wr(ADDR_CNT, 8'h00, RESP_OKAY);
      wr(ADDR_CTL, 8'(i + 2), RESP_OKAY);
      repeat (1024) @(posedge aclk);
      wr(ADDR_CTL, 8'h00, RESP_OKAY);
      rd(ADDR_CNT, 32'(1024 >> sh[i]), RESP_OKAY, 1, "div_count");
    end
    rd(ADDR_SFR, 32'h00, RESP_OKAY, 0, "psr_self_clear");
    for (int m = 0; m < 5; m++) begin
      wr(ADDR_OCR, m == 4 ? 8'hFF : 8'h80, RESP_OKAY);
      wr(ADDR_CTL, pc[m], RESP_OKAY);
      repeat (300) @(posedge aclk);
      hi = 0;
      repeat (pw[m]) begin
        @(posedge aclk);
        hi += pin;
      end
      cmp_num("pwm_high", ph[m], hi, 4);
    end
    rd(ADDR_FLAG, 32'hC0, RESP_OKAY, 0, "flags_set");
    wr(ADDR_CTL, 8'h00, RESP_OKAY);
    wr(ADDR_FLAG, 8'hC0, RESP_OKAY);
    rd(ADDR_FLAG, 32'h00, RESP_OKAY, 0, "flags_clear");
    wr(ADDR_ASYNC, 8'h08, RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp_bit("detached", 1'b1, det);
    wr(ADDR_OCR, 8'h5A, RESP_OKAY);
    rd(ADDR_ASYNC, 32'h0A, RESP_OKAY, 0, "ocr_busy");
    rd(ADDR_OCR, 32'h5A, RESP_OKAY, 0, "ocr_holding");
    wr(ADDR_SFR, 8'h02, RESP_OKAY);
    repeat (150) @(posedge aclk);
    rd(ADDR_ASYNC, 32'h08, RESP_OKAY, 0, "busy_clear");
    rd(ADDR_SFR, 32'h00, RESP_OKAY, 0, "psr_async_clear");
    final_report;
  end
endmodule
